// ==== bc_pkg.sv ====
// Purpose: Shared constants and carriers for the bridge control block
// Assumes: One 50 MHz clock, plain register port with 8-bit byte address
// Notes:   Offsets are byte addresses of 32-bit words
package bc_pkg;

    // Register port geometry
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_BCTL     = 8'h00;
    localparam logic [7:0]  OFF_CMD      = 8'h04;
    localparam logic [7:0]  OFF_ISTAT    = 8'h08;
    localparam logic [7:0]  OFF_IMASK    = 8'h0C;

    // Bridge control field positions
    localparam int          BC_VGA       = 19;
    localparam int          BC_RSVD      = 20;
    localparam int          BC_MAMODE    = 21;
    localparam int          BC_SRST      = 22;
    localparam int          BC_FB2B      = 23;
    localparam int          BC_PTO       = 24;
    localparam int          BC_TOSTAT    = 26;
    localparam logic [31:0] BCTL_RESET   = 32'h0000_0000;

    // Command register field positions
    localparam int          CMD_IO       = 0;
    localparam int          CMD_MEM      = 1;
    localparam int          CMD_SERR     = 8;
    localparam logic [31:0] CMD_RESET    = 32'h0000_0000;

    // Event bits of the interrupt status and mask registers
    localparam int          EV_VGA       = 0;
    localparam int          EV_MABORT    = 1;
    localparam int          EV_TMO       = 2;
    localparam int          EV_W         = 3;
    localparam logic [2:0]  EV_RESET     = 3'h0;

    // Legacy VGA windows
    localparam logic [9:0]  VGA_IO_A_LO  = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI  = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO  = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI  = 10'h3DF;
    localparam logic [15:0] VGA_IO_UPPER = 16'h0000;
    localparam logic [31:0] VGA_MEM_LO   = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI   = 32'h000B_FFFF;
    localparam logic [31:0] ALL_ONES     = 32'hFFFF_FFFF;

    // Primary master time-out lengths in PCI clock cycles
    localparam int          TO_LONG_CYC  = 32768;
    localparam int          TO_SHORT_CYC = 1024;
    localparam int          TO_W         = 16;

    // A transaction seen on either bus
    typedef struct packed {
        logic        valid;
        logic        io;
        logic        mem;
        logic [31:0] addr;
    } bus_req_s;

    // A master abort seen by the initiating side of the bridge
    typedef struct packed {
        logic valid;
        logic delayed;
        logic read;
        logic posted;
    } mabort_s;

    // Answer to the original initiator after a master abort
    typedef struct packed {
        logic        trdy;
        logic        tabort;
        logic [31:0] rdata;
    } ma_resp_s;

endpackage

// ==== dly_timer.sv ====
// Purpose: Primary master time-out for one delayed completion
// Assumes: start and done come from logic on the same clock
// Notes:   clr wins over everything, start wins over a stale done
`timescale 1ns/1ps
module dly_timer
    import bc_pkg::*;
#(
    parameter int LONG_CYC  = TO_LONG_CYC,
    parameter int SHORT_CYC = TO_SHORT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clr,
    input  wire logic start,
    input  wire logic done,
    input  wire logic short_sel,
    output logic      busy,
    output logic      expire
);

    logic [TO_W-1:0] cnt_q;
    logic [TO_W-1:0] cnt_d;
    logic            busy_q;
    logic            busy_d;
    logic            exp_q;
    logic            exp_d;

    // Load on head of queue, count down, fire once at zero
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        exp_d  = 1'b0;
        if (clr) begin
            busy_d = 1'b0;
            cnt_d  = '0;
        end else if (start) begin
            busy_d = 1'b1;
            cnt_d  = short_sel ? TO_W'(SHORT_CYC - 1) : TO_W'(LONG_CYC - 1);
        end else if (busy_q && done) begin
            busy_d = 1'b0;
            cnt_d  = '0;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                exp_d  = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            exp_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            exp_q  <= exp_d;
        end
    end

    assign busy   = busy_q;
    assign expire = exp_q;

endmodule

// ==== bridge_ctrl.sv ====
// Purpose: Bridge control register and the forwarding behaviour it steers
// Assumes: All request inputs come from bus logic on ref_clk
// Notes:   Outputs are registered, so every answer lags its cause by one cycle
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module bridge_ctrl
    import bc_pkg::*;
#(
    parameter int LONG_CYC  = TO_LONG_CYC,
    parameter int SHORT_CYC = TO_SHORT_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire bus_req_s          pri_req,
    output logic                   pri_vga_claim,
    input  wire bus_req_s          sec_req,
    output logic                   sec_vga_refuse,
    input  wire mabort_s           mabort,
    output ma_resp_s               ma_resp,
    output logic                   pri_serr_b,
    output logic                   sec_rst_b,
    input  wire logic              sec_b2b_ok,
    output logic                   sec_fb2b,
    input  wire logic              dly_head,
    input  wire logic              dly_repeat,
    output logic                   dly_discard,
    output logic                   irq
);

    // VGA I/O window: ten low bits only, upper half must be zero
    function automatic logic vga_io_hit(input logic [31:0] a);
        vga_io_hit = (a[31:16] == VGA_IO_UPPER) &&
                     (((a[9:0] >= VGA_IO_A_LO) && (a[9:0] <= VGA_IO_A_HI)) ||
                      ((a[9:0] >= VGA_IO_B_LO) && (a[9:0] <= VGA_IO_B_HI)));
    endfunction

    // Legacy frame buffer window
    function automatic logic vga_mem_hit(input logic [31:0] a);
        vga_mem_hit = (a >= VGA_MEM_LO) && (a <= VGA_MEM_HI);
    endfunction

    // Either window for a given request
    function automatic logic vga_hit(input bus_req_s r);
        vga_hit = r.valid && ((r.io && vga_io_hit(r.addr)) ||
                              (r.mem && vga_mem_hit(r.addr)));
    endfunction

    // Software state
    logic             vga_en_q;
    logic             vga_en_d;
    logic             ma_mode_q;
    logic             ma_mode_d;
    logic             srst_q;
    logic             srst_d;
    logic             fb2b_en_q;
    logic             fb2b_en_d;
    logic             pto_sel_q;
    logic             pto_sel_d;
    logic             tostat_q;
    logic             tostat_d;
    logic             io_en_q;
    logic             io_en_d;
    logic             mem_en_q;
    logic             mem_en_d;
    logic             serr_en_q;
    logic             serr_en_d;
    logic [EV_W-1:0]  istat_q;
    logic [EV_W-1:0]  istat_d;
    logic [EV_W-1:0]  imask_q;
    logic [EV_W-1:0]  imask_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic             irq_q;
    logic             irq_d;

    // Behaviour outputs
    logic             claim_q;
    logic             claim_d;
    logic             refuse_q;
    logic             refuse_d;
    ma_resp_s         resp_q;
    ma_resp_s         resp_d;
    logic             serr_b_q;
    logic             serr_b_d;
    logic             srst_b_q;
    logic             srst_b_d;
    logic             fb2b_q;
    logic             fb2b_d;
    logic             discard_q;
    logic             discard_d;

    logic             wr_bctl;
    logic             wr_cmd;
    logic             wr_istat;
    logic             wr_imask;
    logic [EV_W-1:0]  events;
    logic             tmo_busy;
    logic             tmo_exp;

    assign wr_bctl  = reg_wr && (reg_addr == OFF_BCTL);
    assign wr_cmd   = reg_wr && (reg_addr == OFF_CMD);
    assign wr_istat = reg_wr && (reg_addr == OFF_ISTAT);
    assign wr_imask = reg_wr && (reg_addr == OFF_IMASK);

    // Time-out runs on buffered data, so secondary reset flushes it too
    dly_timer #(
        .LONG_CYC  (LONG_CYC),
        .SHORT_CYC (SHORT_CYC)
    ) u_tmo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .clr       (srst_q),
        .start     (dly_head),
        .done      (dly_repeat),
        .short_sel (pto_sel_q),
        .busy      (tmo_busy),
        .expire    (tmo_exp)
    );

    // Events feeding the sticky status
    always_comb begin
        events            = '0;
        events[EV_VGA]    = claim_d;
        events[EV_MABORT] = mabort.valid;
        events[EV_TMO]    = tmo_exp;
    end

    // Register writes; hardware sets beat a same-cycle W1C clear
    always_comb begin
        vga_en_d  = vga_en_q;
        ma_mode_d = ma_mode_q;
        srst_d    = srst_q;
        fb2b_en_d = fb2b_en_q;
        pto_sel_d = pto_sel_q;
        tostat_d  = tostat_q;
        io_en_d   = io_en_q;
        mem_en_d  = mem_en_q;
        serr_en_d = serr_en_q;
        imask_d   = imask_q;
        istat_d   = istat_q;
        if (wr_bctl) begin
            vga_en_d  = reg_wdata[BC_VGA];
            ma_mode_d = reg_wdata[BC_MAMODE];
            srst_d    = reg_wdata[BC_SRST];
            fb2b_en_d = reg_wdata[BC_FB2B];
            pto_sel_d = reg_wdata[BC_PTO];
            if (reg_wdata[BC_TOSTAT]) begin
                tostat_d = 1'b0;
            end
        end
        if (wr_cmd) begin
            io_en_d   = reg_wdata[CMD_IO];
            mem_en_d  = reg_wdata[CMD_MEM];
            serr_en_d = reg_wdata[CMD_SERR];
        end
        if (wr_imask) begin
            imask_d = reg_wdata[EV_W-1:0];
        end
        if (wr_istat) begin
            istat_d = istat_q & ~reg_wdata[EV_W-1:0];
        end
        istat_d = istat_d | events;
        if (tmo_exp) begin
            tostat_d = 1'b1;
        end
        irq_d = |(istat_d & imask_d);
    end

    // Read mux, answered in the following cycle; unmapped reads zero
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFF_BCTL: begin
                    rdata_d[BC_VGA]    = vga_en_q;
                    rdata_d[BC_RSVD]   = 1'b0;
                    rdata_d[BC_MAMODE] = ma_mode_q;
                    rdata_d[BC_SRST]   = srst_q;
                    rdata_d[BC_FB2B]   = fb2b_en_q;
                    rdata_d[BC_PTO]    = pto_sel_q;
                    rdata_d[BC_TOSTAT] = tostat_q;
                end
                OFF_CMD: begin
                    rdata_d[CMD_IO]   = io_en_q;
                    rdata_d[CMD_MEM]  = mem_en_q;
                    rdata_d[CMD_SERR] = serr_en_q;
                end
                OFF_ISTAT: rdata_d[EV_W-1:0] = istat_q;
                OFF_IMASK: rdata_d[EV_W-1:0] = imask_q;
                default:   rdata_d = '0;
            endcase
        end
    end

    // Software registers; all fields clear on the bridge's own reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vga_en_q  <= BCTL_RESET[BC_VGA];
            ma_mode_q <= BCTL_RESET[BC_MAMODE];
            srst_q    <= BCTL_RESET[BC_SRST];
            fb2b_en_q <= BCTL_RESET[BC_FB2B];
            pto_sel_q <= BCTL_RESET[BC_PTO];
            tostat_q  <= BCTL_RESET[BC_TOSTAT];
            io_en_q   <= CMD_RESET[CMD_IO];
            mem_en_q  <= CMD_RESET[CMD_MEM];
            serr_en_q <= CMD_RESET[CMD_SERR];
            istat_q   <= EV_RESET;
            imask_q   <= EV_RESET;
            rdata_q   <= '0;
            irq_q     <= 1'b0;
        end else begin
            vga_en_q  <= vga_en_d;
            ma_mode_q <= ma_mode_d;
            srst_q    <= srst_d;
            fb2b_en_q <= fb2b_en_d;
            pto_sel_q <= pto_sel_d;
            tostat_q  <= tostat_d;
            io_en_q   <= io_en_d;
            mem_en_q  <= mem_en_d;
            serr_en_q <= serr_en_d;
            istat_q   <= istat_d;
            imask_q   <= imask_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
        end
    end

    // Forwarding and abort behaviour; secondary side held idle in its reset
    always_comb begin
        claim_d   = vga_en_q && io_en_q && mem_en_q && vga_hit(pri_req);
        refuse_d  = !srst_q && vga_hit(sec_req);
        resp_d    = '0;
        serr_b_d  = 1'b1;
        if (mabort.valid && mabort.delayed) begin
            if (ma_mode_q) begin
                resp_d.tabort = 1'b1;
            end else begin
                resp_d.trdy  = 1'b1;
                resp_d.rdata = mabort.read ? ALL_ONES : '0;
            end
        end
        // Mode 0 never drives system error for posted writes
        if (mabort.valid && mabort.posted && ma_mode_q && serr_en_q) begin
            serr_b_d = 1'b0;
        end
        srst_b_d  = !srst_q;
        fb2b_d    = fb2b_en_q && sec_b2b_ok && !srst_q;
        discard_d = tmo_exp;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            claim_q   <= 1'b0;
            refuse_q  <= 1'b0;
            resp_q    <= '0;
            serr_b_q  <= 1'b1;
            srst_b_q  <= 1'b1;
            fb2b_q    <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            claim_q   <= claim_d;
            refuse_q  <= refuse_d;
            resp_q    <= resp_d;
            serr_b_q  <= serr_b_d;
            srst_b_q  <= srst_b_d;
            fb2b_q    <= fb2b_d;
            discard_q <= discard_d;
        end
    end

    // Port drive, all from flops
    assign reg_rdata      = rdata_q;
    assign pri_vga_claim  = claim_q;
    assign sec_vga_refuse = refuse_q;
    assign ma_resp        = resp_q;
    assign pri_serr_b     = serr_b_q;
    assign sec_rst_b      = srst_b_q;
    assign sec_fb2b       = fb2b_q;
    assign dly_discard    = discard_q;
    assign irq            = irq_q;

endmodule

// ==== bridge_ctrl_monitor.sv ====
// Purpose: Port checks for the bridge control block
// Assumes: Shadow bits follow register writes on the same edge as the design
// Notes:   Timer age counts from the last dly_head seen
`timescale 1ns/1ps
module bridge_ctrl_chk
    import bc_pkg::*;
#(
    parameter int LONG_CYC  = TO_LONG_CYC,
    parameter int SHORT_CYC = TO_SHORT_CYC
) (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire bus_req_s          pri_req,
    input wire logic              pri_vga_claim,
    input wire bus_req_s          sec_req,
    input wire logic              sec_vga_refuse,
    input wire mabort_s           mabort,
    input wire ma_resp_s          ma_resp,
    input wire logic              pri_serr_b,
    input wire logic              sec_rst_b,
    input wire logic              sec_b2b_ok,
    input wire logic              sec_fb2b,
    input wire logic              dly_head,
    input wire logic              dly_repeat,
    input wire logic              dly_discard,
    input wire logic              irq
);
    // Shadow: vga, io, mem, srst, fb2b, abort mode, serr en, short time-out
    logic [7:0]  sh_q;
    logic [7:0]  sh_d;
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    always_comb begin
        sh_d = sh_q;
        cnt_d = (cnt_q == 17'h1_FFFF) ? cnt_q : cnt_q + 17'h0_0001;
        if (dly_head) begin
            cnt_d = 17'h0_0000;
        end
        if (reg_wr && reg_addr == OFF_BCTL) begin
            sh_d = {reg_wdata[BC_PTO], sh_q[6], reg_wdata[BC_MAMODE], reg_wdata[BC_FB2B],
                    reg_wdata[BC_SRST], sh_q[2:1], reg_wdata[BC_VGA]};
        end
        if (reg_wr && reg_addr == OFF_CMD) begin
            sh_d = {sh_q[7], reg_wdata[CMD_SERR], sh_q[5:3], reg_wdata[CMD_MEM],
                    reg_wdata[CMD_IO], sh_q[0]};
        end
    end
    // Saturating age avoids a false wrap on long idle runs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= 8'h00;
            cnt_q <= 17'h1_FFFF;
        end else begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_rsvd;
        $past(reg_rd && reg_addr == OFF_BCTL) |-> reg_rdata[BC_RSVD] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
    property p_enab;
        pri_vga_claim |-> $past(pri_req.valid && sh_q[2:0] == 3'h7);
    endproperty
    a_enab: assert property (p_enab) else $error("claim without enables");
    property p_iowin;
        pri_vga_claim && $past(pri_req.io) |-> $past(pri_req.addr[31:16] == VGA_IO_UPPER &&
            pri_req.addr[9:0] inside {[VGA_IO_A_LO:VGA_IO_A_HI], [VGA_IO_B_LO:VGA_IO_B_HI]});
    endproperty
    a_iowin: assert property (p_iowin) else $error("io claim outside window");
    property p_memwin;
        pri_vga_claim && !$past(pri_req.io) |-> $past(pri_req.addr) inside {[VGA_MEM_LO:VGA_MEM_HI]};
    endproperty
    a_memwin: assert property (p_memwin) else $error("memory claim outside window");
    property p_trdy;
        ma_resp.trdy |-> !ma_resp.tabort && $past(mabort.valid && mabort.delayed && !sh_q[5])
            && ma_resp.rdata == ($past(mabort.read) ? ALL_ONES : 32'h0000_0000);
    endproperty
    a_trdy: assert property (p_trdy) else $error("bad ready answer to abort");
    property p_tabort;
        $past(mabort.valid && mabort.delayed && sh_q[5]) |-> ma_resp.tabort && !ma_resp.trdy;
    endproperty
    a_tabort: assert property (p_tabort) else $error("target abort missing");
    property p_serr;
        !pri_serr_b |-> $past(mabort.valid && mabort.posted && sh_q[5] && sh_q[6]);
    endproperty
    a_serr: assert property (p_serr) else $error("system error without cause");
    property p_srst;
        sec_rst_b == !$past(sh_q[3]);
    endproperty
    a_srst: assert property (p_srst) else $error("secondary reset mismatch");
    property p_fb2b;
        sec_fb2b |-> $past(sh_q[4] && !sh_q[3] && sec_b2b_ok);
    endproperty
    a_fb2b: assert property (p_fb2b) else $error("fast back-to-back not enabled");
    property p_tmo;
        dly_discard |-> cnt_q == (sh_q[7] ? SHORT_CYC + 1 : LONG_CYC + 1);
    endproperty
    a_tmo: assert property (p_tmo) else $error("discard at wrong age");
endmodule

bind bridge_ctrl bridge_ctrl_chk #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_chk (.*);

// ==== pci_agent.sv ====
// Purpose: Primary and secondary bus parties facing the bridge control block
// Assumes: Each task starts its pulse just after a rising edge
// Notes:   Released request and abort lines show the inverse of the last value, valid low; head lines drop to zero
`timescale 1ns/1ps
module pci_agent
    import bc_pkg::*;
(
    input  wire logic ref_clk,
    output bus_req_s  pri_req,
    output bus_req_s  sec_req,
    output mabort_s   mabort,
    output logic      dly_head,
    output logic      dly_repeat,
    output logic      sec_b2b_ok
);
    initial begin
        pri_req = '0;
        sec_req = '0;
        mabort = '0;
        dly_head = 1'b0;
        dly_repeat = 1'b0;
        sec_b2b_ok = 1'b0;
    end
    // One transaction sample on the chosen bus
    task automatic req(input bus_req_s r, input logic sec);
        @(posedge ref_clk);
        pri_req <= sec ? pri_req : r;
        sec_req <= sec ? r : sec_req;
        @(posedge ref_clk);
        pri_req <= sec ? pri_req : ~r;
        sec_req <= sec ? ~r : sec_req;
    endtask
    task automatic abort(input mabort_s m);
        @(posedge ref_clk);
        mabort <= m;
        @(posedge ref_clk);
        mabort <= ~m;
    endtask
    // Completion at queue head, or the initiator coming back for it
    task automatic head(input logic rep);
        @(posedge ref_clk);
        dly_head <= !rep;
        dly_repeat <= rep;
        @(posedge ref_clk);
        dly_head <= 1'b0;
        dly_repeat <= 1'b0;
    endtask
    task automatic ok(input logic v);
        @(posedge ref_clk);
        sec_b2b_ok <= v;
    endtask
endmodule

// ==== bridge_ctrl_test.sv ====
// Purpose: Register, decode, abort and timer scenarios for the bridge control block
// Assumes: Time-outs shortened to 40 and 10 cycles
// Notes:   Outputs are sampled 1 ns after the edge that updates them
`timescale 1ns/1ps
module bridge_ctrl_test
    import bc_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    bus_req_s          pri_req;
    bus_req_s          sec_req;
    mabort_s           mabort;
    ma_resp_s          ma_resp;
    logic              pri_vga_claim, sec_vga_refuse, pri_serr_b, sec_rst_b;
    logic              sec_b2b_ok, sec_fb2b, dly_head, dly_repeat, dly_discard, irq;
    int                errors = 0;
    int                checks = 0;
    int                n;
    localparam logic [31:0] VA [10] = '{32'h0000_03B0, 32'h0000_03BB, 32'h0000_03BC,
        32'h0000_FFC0, 32'h0000_03DF, 32'h0000_03E0, 32'h0001_03C0, 32'h000A_0000,
        32'h000B_FFFF, 32'h000C_0000};
    localparam logic [9:0]  VH = 10'h19B;
    always #10 ref_clk = ~ref_clk;
    bridge_ctrl #(.LONG_CYC(40), .SHORT_CYC(10)) u_dut (.*);
    pci_agent u_agent (.*);
    task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_b(input logic got, input logic exp);
        cmp_w({31'h0, got}, {31'h0, exp});
    endtask
    // Register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 cmp_w(reg_rdata, exp);
    endtask
    function automatic bus_req_s mk(input logic io, input logic [31:0] a);
        return '{1'b1, io, !io, a};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        // Register port idle from time zero, driven only by these tasks
        reg_addr <= '0;
        reg_wdata <= '0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(OFF_BCTL, BCTL_RESET);
        rd(OFF_CMD, CMD_RESET);
        rd(8'h10, 32'h0000_0000);
        u_agent.ok(1'b1);
        wr(OFF_CMD, 32'h0000_0103);
        wr(OFF_BCTL, ALL_ONES);
        rd(OFF_BCTL, 32'h01E8_0000);
        cmp_b(sec_rst_b, 1'b0);
        cmp_b(sec_fb2b, 1'b0);
        rd(OFF_CMD, 32'h0000_0103);
        wr(OFF_BCTL, 32'h0080_0000);
        rd(OFF_BCTL, 32'h0080_0000);
        cmp_b(sec_rst_b, 1'b1);
        cmp_b(sec_fb2b, 1'b1);
        // Enabled but the secondary master cannot chain: no fast back-to-back
        u_agent.ok(1'b0);
        @(posedge ref_clk);
        #1 cmp_b(sec_fb2b, 1'b0);
        u_agent.ok(1'b1);
        wr(OFF_BCTL, 32'h0008_0000);
        wr(OFF_IMASK, 32'h0000_0001);
        #1 cmp_b(sec_fb2b, 1'b0);
        // Window edges, ignored bits 15:10 and a non-zero upper half
        for (int i = 0; i < 10; i++) begin
            u_agent.req(mk(i < 7, VA[i]), 1'b0);
            #1 cmp_b(pri_vga_claim, VH[i]);
        end
        rd(OFF_ISTAT, 32'h0000_0001);
        cmp_b(irq, 1'b1);
        wr(OFF_ISTAT, 32'h0000_0001);
        rd(OFF_ISTAT, 32'h0000_0000);
        cmp_b(irq, 1'b0);
        wr(OFF_IMASK, 32'h0000_0000);
        u_agent.req(mk(1'b1, VA[0]), 1'b0);
        rd(OFF_ISTAT, 32'h0000_0001);
        cmp_b(irq, 1'b0);
        wr(OFF_CMD, 32'h0000_0101);
        u_agent.req(mk(1'b1, VA[0]), 1'b0);
        #1 cmp_b(pri_vga_claim, 1'b0);
        u_agent.req(mk(1'b1, VA[4]), 1'b1);
        #1 cmp_b(sec_vga_refuse, 1'b1);
        cmp_b(pri_vga_claim, 1'b0);
        // Delayed read, delayed write and posted write in both abort modes
        for (int m = 0; m < 2; m++) begin
            wr(OFF_BCTL, m ? 32'h0020_0000 : 32'h0000_0000);
            for (int k = 0; k < 3; k++) begin
                u_agent.abort('{1'b1, k < 2, k == 0, k == 2});
                #1 cmp_b(ma_resp.trdy, m == 0 && k < 2);
                cmp_b(ma_resp.tabort, m == 1 && k < 2);
                if (m == 0) cmp_w(ma_resp.rdata, k == 0 ? ALL_ONES : 32'h0000_0000);
                cmp_b(pri_serr_b, !(m == 1 && k == 2));
            end
        end
        wr(OFF_CMD, 32'h0000_0003);
        u_agent.abort('{1'b1, 1'b0, 1'b0, 1'b1});
        #1 cmp_b(pri_serr_b, 1'b1);
        // Long then short time-out; the second write also clears the status
        for (int s = 0; s < 2; s++) begin
            wr(OFF_BCTL, s ? 32'h0500_0000 : 32'h0000_0000);
            u_agent.head(1'b0);
            n = 0;
            while (dly_discard !== 1'b1 && n < 60) begin
                @(posedge ref_clk);
                #1 n++;
            end
            // Expiry after the full count, discard pulse one registered cycle later
            cmp_w(32'(n), s ? 32'h0000_000B : 32'h0000_0029);
            if (n >= 60) print_verdict();
            rd(OFF_BCTL, s ? 32'h0500_0000 : 32'h0400_0000);
        end
        wr(OFF_BCTL, 32'h0500_0000);
        u_agent.head(1'b0);
        u_agent.head(1'b1);
        n = 0;
        repeat (20) begin
            @(posedge ref_clk);
            #1 if (dly_discard !== 1'b0) n++;
        end
        cmp_w(32'(n), 32'h0000_0000);
        rd(OFF_BCTL, 32'h0100_0000);
        print_verdict();
    end
endmodule
